// file: logic/csi_pkg.sv
package csi_pkg;
  // Channel count and phase inputs per channel
  localparam int CSI_NUM_CH = 2;
  localparam int CSI_NUM_PH = 3;
  localparam int CSI_NUM_DIO = 2;
  // Register offsets (byte addresses)
  localparam logic [7:0] CSI_OFF_CTRL = 8'h00;
  localparam logic [7:0] CSI_OFF_STAT = 8'h04;
  localparam logic [7:0] CSI_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] CSI_OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] CSI_OFF_CFG = 8'h10;
  // Control fields
  localparam int CSI_CTRL_INIT_DONE = 0;
  localparam int CSI_CTRL_HOST_ERR = 1;
  localparam int CSI_CTRL_CFG_MISMATCH = 2;
  // Interrupt event bit positions
  localparam int CSI_EV_UNIT_ERR = 0;
  localparam int CSI_EV_HOST_ERR = 1;
  localparam int CSI_EV_CFG_ERR = 2;
  localparam int CSI_EV_W = 3;
  // Default all-zero channel settings for simple counters
  localparam logic [15:0] CSI_CFG_DEFAULT = 16'h0000;
  localparam logic [31:0] CSI_ZERO = 32'h0000_0000;
  // Initialisation length in cycles after reset
  localparam logic [3:0] CSI_INIT_CYCLES = 4'h8;

  // Counter type selected per channel
  typedef enum logic [1:0] {
    CSI_TYPE_SIMPLE = 2'b00,
    CSI_TYPE_CIRCULAR = 2'b01,
    CSI_TYPE_LINEAR = 2'b10
  } csi_type_t;

  // Unit state
  typedef enum logic [1:0] {
    CSI_ST_INIT = 2'b00,
    CSI_ST_RUN = 2'b01,
    CSI_ST_FAULT = 2'b10
  } csi_state_t;

  // Per-channel lamp group
  typedef struct packed {
    logic gate;
    logic [2:0] phase;
  } csi_ch_lamp_t;

  // Unit-level lamp group
  typedef struct packed {
    logic run;
    logic unit_error;
    logic host_error;
  } csi_unit_lamp_t;
endpackage

// file: logic/csi_indicators.sv
`timescale 1ns/1ps
// Behaviour
// - Operating lamp lit after normal initialisation
// - Operating lamp dark when absent/watchdog/hardware fault
// - Unit-error lamp follows error blocking operation
// - Host-error lamp follows host failure report
// - Channel lamp lit while counting gate open
// - One lamp per phase input A/B/Z
// - Lamp follows each digital input
// - Lamp follows each digital output
// - Switch positions select channel counter type
// - All channels simple when switch off
// - Simple channel uses all-zero settings
// - Host picks circular or linear type
// - Simple channel gets reduced feature set
// - Config mismatch error cleared only by reset
module csi_indicators
  import csi_pkg::*;
#(
  parameter int NCH = CSI_NUM_CH,
  parameter int NDIO = CSI_NUM_DIO
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Unit condition inputs
  input wire logic unit_registered,
  input wire logic unit_watchdog,
  input wire logic hw_fault,
  input wire logic unit_fault,
  // Field signals
  input wire logic [NCH-1:0] gate_open,
  input wire logic [NCH*3-1:0] phase_in,
  input wire logic [NDIO-1:0] digital_input_pair,
  input wire logic [NDIO-1:0] digital_output_pair,
  input wire logic [NCH-1:0] type_switch,
  // Lamps
  output logic run_lamp,
  output logic unit_error_lamp,
  output logic host_error_lamp,
  output logic [NCH-1:0] channel_gate_lamp,
  output logic [NCH*3-1:0] phase_lamp,
  output logic [NDIO-1:0] din_lamp,
  output logic [NDIO-1:0] dout_lamp,
  // Counter configuration to counting logic
  output logic [NCH*2-1:0] chan_type,
  output logic [NCH-1:0] chan_full_features,
  output logic [NCH*16-1:0] chan_cfg,
  // Interrupt
  output logic irq
);

  // Unit state and init counter
  csi_state_t state_q;
  logic [3:0] init_cnt_q;
  // Latched switch positions, sampled on every initialisation cycle
  logic [NCH-1:0] sw_q;
  // Software-written control and per-channel settings
  logic [2:0] ctrl_q;
  logic [NCH*2-1:0] cfg_circ_q;
  logic [NCH*16-1:0] cfg_val_q;
  // Sticky config-mismatch error
  logic cfg_err_q;
  // Interrupt status and mask
  logic [CSI_EV_W-1:0] ist_q;
  logic [CSI_EV_W-1:0] imask_q;
  // Previous event levels for edge detection
  logic [CSI_EV_W-1:0] ev_prev_q;
  logic [CSI_EV_W-1:0] ev_now;
  logic [CSI_EV_W-1:0] ev_rise;
  // Unit cannot operate
  logic unit_dead;

  // Decoding of register address, used by the write paths; reads decode with a case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Any one of these keeps the operating lamp dark until reset
  assign unit_dead = !unit_registered || unit_watchdog || hw_fault;

  // Initialisation sequence
  // A fault seen while counting aborts straight to the fault state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= CSI_ST_INIT;
      init_cnt_q <= 4'h0;
    end else if (clk_en) begin
      case (state_q)
        CSI_ST_INIT: begin
          if (unit_dead) begin
            state_q <= CSI_ST_FAULT;
          end else if (init_cnt_q == CSI_INIT_CYCLES - 4'h1) begin
            state_q <= CSI_ST_RUN;
          end else begin
            init_cnt_q <= init_cnt_q + 4'h1;
          end
        end
        CSI_ST_RUN: begin
          // Faults drop the unit out of operation until reset
          if (unit_dead) begin
            state_q <= CSI_ST_FAULT;
          end
        end
        CSI_ST_FAULT: begin
          state_q <= CSI_ST_FAULT;
        end
        default: begin
          state_q <= CSI_ST_INIT;
        end
      endcase
    end
  end

  // Switch capture only while initialising, so a moved switch is ignored live
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sw_q <= '0;
    end else if (clk_en && state_q == CSI_ST_INIT) begin
      sw_q <= type_switch;
    end
  end

  // Control and configuration writes
  // Writes to unmapped offsets fall through every branch and are lost
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_q <= 3'h0;
      cfg_circ_q <= '0;
      cfg_val_q <= '0;
      imask_q <= '0;
    end else if (clk_en && reg_wr) begin
      if (hit(reg_addr, CSI_OFF_CTRL)) begin
        ctrl_q <= reg_wdata[2:0];
      end
      if (hit(reg_addr, CSI_OFF_IRQ_MASK)) begin
        imask_q <= reg_wdata[CSI_EV_W-1:0];
      end
      if (hit(reg_addr, CSI_OFF_CFG)) begin
        // Whole word: one 16-bit setting word per channel; circular pick is written at CSI_OFF_STAT
        cfg_val_q <= reg_wdata[NCH*16-1:0];
      end
      if (hit(reg_addr, CSI_OFF_STAT)) begin
        cfg_circ_q <= reg_wdata[NCH*2-1:0];
      end
    end
  end

  // Mismatch error is sticky; only reset clears it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_err_q <= 1'b0;
    end else if (clk_en && ctrl_q[CSI_CTRL_CFG_MISMATCH]) begin
      cfg_err_q <= 1'b1;
    end
  end

  // Counter type and settings per channel
  // The switch copy only moves in initialisation, so a live flip waits for reset
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          chan_type[g*2 +: 2] <= CSI_TYPE_SIMPLE;
          chan_cfg[g*16 +: 16] <= CSI_CFG_DEFAULT;
          chan_full_features[g] <= 1'b0;
        end else if (clk_en) begin
          if (sw_q[g]) begin
            // Host picks circular or linear
            chan_type[g*2 +: 2] <= cfg_circ_q[g*2] ? CSI_TYPE_CIRCULAR
                                                   : CSI_TYPE_LINEAR;
            chan_cfg[g*16 +: 16] <= cfg_val_q[g*16 +: 16];
            chan_full_features[g] <= 1'b1;
          end else begin
            chan_type[g*2 +: 2] <= CSI_TYPE_SIMPLE;
            chan_cfg[g*16 +: 16] <= CSI_CFG_DEFAULT;
            chan_full_features[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Lamps, all registered
  // One cycle of latency on every lamp, traded for glitch-free pins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      run_lamp <= 1'b0;
      unit_error_lamp <= 1'b0;
      host_error_lamp <= 1'b0;
      channel_gate_lamp <= '0;
      phase_lamp <= '0;
      din_lamp <= '0;
      dout_lamp <= '0;
    end else if (clk_en) begin
      run_lamp <= (state_q == CSI_ST_RUN) && !unit_dead;
      unit_error_lamp <= unit_fault || cfg_err_q;
      host_error_lamp <= ctrl_q[CSI_CTRL_HOST_ERR];
      channel_gate_lamp <= gate_open;
      phase_lamp <= phase_in;
      din_lamp <= digital_input_pair;
      dout_lamp <= digital_output_pair;
    end
  end

  // Event levels and their rising edges
  // Edges, not levels, so a condition held high raises its status bit once
  assign ev_now = {cfg_err_q, ctrl_q[CSI_CTRL_HOST_ERR], unit_fault};
  assign ev_rise = ev_now & ~ev_prev_q;

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ist_q <= '0;
      ev_prev_q <= '0;
    end else if (clk_en) begin
      ev_prev_q <= ev_now;
      if (reg_wr && hit(reg_addr, CSI_OFF_IRQ_STAT)) begin
        ist_q <= (ist_q & ~reg_wdata[CSI_EV_W-1:0]) | ev_rise;
      end else begin
        ist_q <= ist_q | ev_rise;
      end
    end
  end

  // Level interrupt, high until software clears or masks the status bit
  assign irq = |(ist_q & imask_q);

  // Read data, one cycle after the strobe
  // Idle cycles and unmapped offsets read back as zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= CSI_ZERO;
    end else if (clk_en) begin
      reg_rdata <= CSI_ZERO;
      if (reg_rd) begin
        case (reg_addr)
          CSI_OFF_CTRL: reg_rdata <= {29'h0, ctrl_q};
          CSI_OFF_STAT: reg_rdata <= {24'h0, cfg_err_q, unit_dead, state_q,
                                      2'h0, sw_q};
          CSI_OFF_IRQ_STAT: reg_rdata <= {29'h0, ist_q};
          CSI_OFF_IRQ_MASK: reg_rdata <= {29'h0, imask_q};
          CSI_OFF_CFG: reg_rdata <= cfg_val_q;
          default: reg_rdata <= CSI_ZERO;
        endcase
      end
    end
  end

  // Checks. Reset is synchronous, so all antecedents but the three hold checks also require !sys_rst: the
  // release edge must not start an attempt that sees reset-time outputs.

  // Operating lamp dark while the unit cannot operate
  chk_run_lamp_dead: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !sys_rst && unit_dead |=> !run_lamp)
    else $error("run lamp lit while unit cannot operate");

  // A fault holds the unit out of operation until reset
  chk_fault_latched: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == CSI_ST_FAULT |=> state_q == CSI_ST_FAULT)
    else $error("unit left fault state without reset");

  // Operating lamp lit once operating and healthy
  chk_run_after_init: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !sys_rst && state_q == CSI_ST_RUN && !unit_dead |=> run_lamp)
    else $error("run lamp dark in operation");

  // Last counted initialisation cycle enters operation
  chk_init_to_run: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !sys_rst && state_q == CSI_ST_INIT && !unit_dead &&
    init_cnt_q == CSI_INIT_CYCLES - 4'h1 |=> state_q == CSI_ST_RUN)
    else $error("initialisation did not end in operation");

  // Gate lamps one cycle behind the gates
  chk_gate_lamp: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !sys_rst |=> channel_gate_lamp == $past(gate_open))
    else $error("gate lamp wrong");

  // Phase lamps one cycle behind the phase inputs
  chk_phase_lamp: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !sys_rst |=> phase_lamp == $past(phase_in))
    else $error("phase lamp wrong");

  // Input lamps one cycle behind the digital inputs
  chk_dio_lamps: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !sys_rst |=> din_lamp == $past(digital_input_pair))
    else $error("input lamp wrong");

  // Output lamps one cycle behind the digital outputs
  chk_dout_lamps: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !sys_rst |=> dout_lamp == $past(digital_output_pair))
    else $error("output lamp wrong");

  // Host lamp one cycle behind the host failure flag
  chk_host_lamp: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !sys_rst |=> host_error_lamp == $past(ctrl_q[CSI_CTRL_HOST_ERR]))
    else $error("host lamp wrong");

  // Setting-check error never falls without reset
  chk_cfg_err_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cfg_err_q |=> cfg_err_q)
    else $error("mismatch error cleared without reset");

  // First channel in simple mode runs on zero settings
  chk_simple_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !sys_rst && !sw_q[0] |=>
      chan_cfg[15:0] == CSI_CFG_DEFAULT && !chan_full_features[0])
    else $error("simple channel not defaulted");

  // Second channel in simple mode runs on zero settings
  chk_simple_zero_hi: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !sys_rst && !sw_q[1] |=>
      chan_cfg[31:16] == CSI_CFG_DEFAULT && !chan_full_features[1])
    else $error("second simple channel not defaulted");

  // Switch on gives the first channel the full feature set
  chk_full_feat: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !sys_rst && sw_q[0] |=> chan_full_features[0])
    else $error("full features missing on switched channel");

  // Switch copy frozen outside initialisation
  chk_switch_frozen: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q != CSI_ST_INIT |=> $stable(sw_q))
    else $error("switch sampled outside initialisation");

  // Unit error lamp lit on a blocking error
  chk_unit_err: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !sys_rst && unit_fault |=> unit_error_lamp)
    else $error("unit error lamp dark on fault");

  // Unit error lamp dark when nothing blocks operation
  chk_unit_err_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !sys_rst && !unit_fault && !cfg_err_q |=> !unit_error_lamp)
    else $error("unit error lamp lit without error");

  // Main scenarios reached
  cov_run: cover property (@(posedge ref_clk) state_q == CSI_ST_INIT ##1 state_q == CSI_ST_RUN);
  cov_fault: cover property (@(posedge ref_clk) state_q == CSI_ST_RUN ##1 state_q == CSI_ST_FAULT);
  cov_circ: cover property (@(posedge ref_clk) chan_type[1:0] == CSI_TYPE_CIRCULAR);
  cov_linear: cover property (@(posedge ref_clk) chan_type[1:0] == CSI_TYPE_LINEAR);
  cov_irq: cover property (@(posedge ref_clk) irq);

endmodule // csi_indicators

// file: testbench/csi_field_model.sv
`timescale 1ns/1ps
module csi_field_model (
  // Clock
  input wire logic ref_clk,
  // Wanted host and field levels
  input wire logic [17:0] want,
  // Lines into the unit
  output logic unit_registered,
  output logic unit_watchdog,
  output logic hw_fault,
  output logic unit_fault,
  output logic [1:0] type_switch,
  output logic [1:0] gate_open,
  output logic [5:0] phase_in,
  output logic [1:0] din,
  output logic [1:0] dout
);
  // Levels move only after an edge, like real wiring into a synchronous unit
  logic [17:0] lvl_q;
  // Apply the wanted levels one edge late
  always_ff @(posedge ref_clk) begin
    lvl_q <= want;
  end
  // Unpack; the switch is a plain level, host picks the type later
  assign {unit_registered, unit_watchdog, hw_fault, unit_fault, type_switch, gate_open,
          phase_in, din, dout} = lvl_q;
endmodule // csi_field_model

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import csi_pkg::*;
  logic ref_clk = 1'b0; // Bench clock
  logic sys_rst = 1'b1; // Reset
  logic ce = 1'b1; // Clock enable, dropped only by the freeze scenario
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  logic [17:0] fld = 18'h20000; // Field levels wanted
  logic ureg, uwdt, uhw, uflt, run_lamp, unit_error_lamp, host_error_lamp, irq;
  logic [1:0] sw, gate, din, dout, cgl, dinl, doutl, ffeat;
  logic [5:0] ph, phl;
  logic [3:0] ctype;
  logic [31:0] ccfg;
  int failures = 0;
  int checks = 0;
  // 25 MHz
  always #20 ref_clk = ~ref_clk;
  csi_field_model fld_u (.ref_clk(ref_clk), .want(fld), .unit_registered(ureg),
    .unit_watchdog(uwdt), .hw_fault(uhw), .unit_fault(uflt), .type_switch(sw),
    .gate_open(gate), .phase_in(ph), .din(din), .dout(dout));
  csi_indicators dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .unit_registered(ureg), .unit_watchdog(uwdt), .hw_fault(uhw),
    .unit_fault(uflt), .gate_open(gate), .phase_in(ph), .digital_input_pair(din),
    .digital_output_pair(dout), .type_switch(sw), .run_lamp(run_lamp),
    .unit_error_lamp(unit_error_lamp), .host_error_lamp(host_error_lamp),
    .channel_gate_lamp(cgl), .phase_lamp(phl), .din_lamp(dinl), .dout_lamp(doutl),
    .chan_type(ctype), .chan_full_features(ffeat), .chan_cfg(ccfg), .irq(irq));
  // Verdict, one exit for all paths
  task automatic tally_and_finish;
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Compare two values
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Wait n edges, then look once settled
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Single-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read: data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Reset with given field levels, then wait out initialisation
  task automatic boot(input logic [17:0] f);
    int i;
    @(posedge ref_clk);
    fld <= f;
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1 chk(run_lamp, 0);
    for (i = 0; i < 40 && run_lamp !== 1'b1; i++) tick(1);
    chk(i, CSI_INIT_CYCLES + 1);
    if (run_lamp !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
  endtask
  // Default switch: every channel simple with zero settings
  task automatic t_default;
    boot(18'h20000);
    wr(CSI_OFF_CFG, 32'h1234_5678);
    tick(2);
    chk(ctype, 0);
    chk(ccfg, 0);
    chk(ffeat, 0);
  endtask
  // Lamps follow the field lines, both polarities
  task automatic t_lamps;
    logic [11:0] p;
    for (int j = 0; j < 2; j++) begin
      p = j ? 12'h5a6 : 12'ha59;
      fld <= {6'h20, p};
      tick(3);
      chk(cgl, p[11:10]);
      chk(phl, p[9:4]);
      chk(dinl, p[3:2]);
      chk(doutl, p[1:0]);
    end
  endtask
  // Clock enable low freezes the lamps; raising it lets them follow again
  task automatic t_freeze;
    @(posedge ref_clk);
    ce <= 1'b0;
    fld <= {6'h20, 12'ha59};
    tick(3);
    chk(cgl, 2'h1);
    chk(phl, 6'h1a);
    @(posedge ref_clk);
    ce <= 1'b1;
    tick(2);
    chk(cgl, 2'h2);
    chk(phl, 6'h25);
  endtask
  // Host failure lamp and its interrupt: raise, mask, clear
  task automatic t_host;
    wr(CSI_OFF_IRQ_MASK, 32'h2);
    rd(CSI_OFF_IRQ_MASK, d);
    chk(d, 32'h2);
    wr(CSI_OFF_CTRL, 32'h2);
    tick(2);
    chk(host_error_lamp, 1);
    chk(irq, 1);
    wr(CSI_OFF_IRQ_MASK, 32'h0);
    tick(1);
    chk(irq, 0);
    wr(CSI_OFF_CTRL, 32'h0);
    wr(CSI_OFF_IRQ_STAT, 32'h2);
    tick(2);
    chk(host_error_lamp, 0);
    rd(CSI_OFF_IRQ_STAT, d);
    chk(d[2:0], 0);
    rd(8'hf0, d);
    chk(d, 0);
  endtask
  // Unit error lamp follows the blocking error
  task automatic t_unit;
    fld <= 18'h24000;
    tick(3);
    chk(unit_error_lamp, 1);
    rd(CSI_OFF_IRQ_STAT, d);
    chk(d[0], 1);
    fld <= 18'h20000;
    tick(3);
    chk(unit_error_lamp, 0);
  endtask
  // Switch on channel 0 only; host picks circular then linear
  task automatic t_types;
    boot(18'h21000);
    wr(CSI_OFF_CFG, 32'hbeef_1234);
    wr(CSI_OFF_STAT, 32'h1);
    tick(2);
    chk(ctype, 4'h1);
    chk(ffeat, 2'h1);
    wr(CSI_OFF_STAT, 32'h0);
    tick(2);
    chk(ctype, 4'h2);
    chk(ccfg, 32'h0000_1234);
    rd(CSI_OFF_CFG, d);
    chk(d, 32'hbeef_1234);
    fld <= 18'h22000;
    tick(3);
    rd(CSI_OFF_STAT, d);
    chk(d[1:0], 2'h1);
  endtask
  // Setting-check error holds until a reset
  task automatic t_sticky;
    wr(CSI_OFF_CTRL, 32'h4);
    wr(CSI_OFF_CTRL, 32'h0);
    tick(2);
    rd(CSI_OFF_STAT, d);
    chk(d[7], 1);
    boot(18'h20000);
    rd(CSI_OFF_STAT, d);
    chk(d[7], 0);
  endtask
  // Absent, watchdog, hardware fault each darken the operating lamp
  task automatic t_fault;
    for (int i = 0; i < 3; i++) begin
      boot(18'h20000);
      fld <= 18'h20000 ^ (18'h20000 >> i);
      tick(3);
      chk(run_lamp, 0);
      fld <= 18'h20000;
      tick(3);
      chk(run_lamp, 0);
    end
  endtask
  // Main sequence
  initial begin
    t_default();
    t_lamps();
    t_freeze();
    t_host();
    t_unit();
    t_types();
    t_sticky();
    t_fault();
    tally_and_finish();
  end
endmodule // tb
